// ### logic/irq_pending_priority_ctrl.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module irq_pending_priority_ctrl #(
  parameter int unsigned NUM_IRQ = 240,
  parameter int unsigned PRIO_BITS = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_IRQ-1:0] irq_req_i,
  input wire logic [NUM_IRQ-1:0] irq_enable_i,
  input wire logic handler_entry_i,
  input wire logic handler_return_i,
  input wire logic [7:0] handler_irq_i,
  output logic [NUM_IRQ-1:0] pending_o,
  output logic [NUM_IRQ-1:0] active_o,
  output irq_ctrl_pkg::sel_s sel_o
);
  // write channel holding registers
  logic aw_held;
  logic [11:0] aw_addr;
  logic aw_priv;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  // read channel
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  // software-visible control
  logic user_pend_permission;
  logic [irq_ctrl_pkg::BITMAP_W-1:0] sense_pulsed;
  logic [NUM_IRQ-1:0] sense_q;
  // request synchronisers
  logic [NUM_IRQ-1:0] req_s1;
  logic [NUM_IRQ-1:0] req_s2;
  logic [NUM_IRQ-1:0] req_s3;
  // padded state views for read-back
  logic [irq_ctrl_pkg::BITMAP_W-1:0] pend_pad;
  logic [irq_ctrl_pkg::BITMAP_W-1:0] act_pad;
  logic [irq_ctrl_pkg::PRIO_WORDS*32-1:0] prio_pad;
  logic [PRIO_BITS-1:0] prio [NUM_IRQ];
  irq_ctrl_pkg::sel_s next_sel;
  logic [NUM_IRQ-1:0] cand;

  // write address decode
  logic do_wr;
  logic wr_hit_ctrl;
  logic wr_hit_sense;
  logic wr_hit_set;
  logic wr_hit_clr;
  logic wr_hit_act;
  logic wr_hit_prio;
  logic wr_hit_trig;
  logic wr_mapped;
  logic wr_allowed;
  logic wr_go;
  logic [2:0] wr_word;
  logic [5:0] wr_pword;
  logic [irq_ctrl_pkg::TRIG_ID_W-1:0] trig_id;
  logic trig_go;
  logic aw_take;
  logic w_take;
  logic b_done;
  logic [1:0] next_bresp;

  assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take = s_axi_wvalid_i & s_axi_wready_o;
  assign b_done = bvalid & s_axi_bready_i;
  assign do_wr = aw_held & w_held & ~bvalid;
  // low two address bits ignored, aligned access assumed [R21]
  assign wr_word = aw_addr[4:2];
  assign wr_pword = aw_addr[7:2];
  assign wr_hit_ctrl = (aw_addr[11:2] == irq_ctrl_pkg::CTRL_ADDR[11:2]);
  assign wr_hit_sense = (aw_addr >= irq_ctrl_pkg::SENSE_BASE) &&
                        (aw_addr <= irq_ctrl_pkg::SENSE_BASE +
                         irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  assign wr_hit_set = (aw_addr >= irq_ctrl_pkg::SET_BASE) &&
                      (aw_addr <= irq_ctrl_pkg::SET_BASE + irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  assign wr_hit_clr = (aw_addr >= irq_ctrl_pkg::CLR_BASE) &&
                      (aw_addr <= irq_ctrl_pkg::CLR_BASE + irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  assign wr_hit_act = (aw_addr >= irq_ctrl_pkg::ACT_BASE) &&
                      (aw_addr <= irq_ctrl_pkg::ACT_BASE + irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  assign wr_hit_prio = (aw_addr >= irq_ctrl_pkg::PRIO_BASE) &&
                       (aw_addr <= irq_ctrl_pkg::PRIO_LAST);
  assign wr_hit_trig = (aw_addr[11:2] == irq_ctrl_pkg::TRIG_ADDR[11:2]);
  assign wr_mapped = wr_hit_ctrl | wr_hit_sense | wr_hit_set | wr_hit_clr |
                     wr_hit_act | wr_hit_prio | wr_hit_trig;
  // trigger open to unprivileged writes only with permission set [R10]
  assign wr_allowed = wr_mapped & (aw_priv | (wr_hit_trig & user_pend_permission));
  assign wr_go = do_wr & wr_allowed;
  assign trig_id = w_data[irq_ctrl_pkg::TRIG_ID_W-1:0];
  assign trig_go = wr_go & wr_hit_trig & w_strb[0] & w_strb[1];
  assign next_bresp = wr_allowed ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;

  // read address decode
  logic do_rd;
  logic rd_priv;
  logic rd_hit_ctrl;
  logic rd_hit_sense;
  logic rd_hit_pend;
  logic rd_hit_act;
  logic rd_hit_prio;
  logic rd_hit_trig;
  logic [2:0] rd_word;
  logic [5:0] rd_pword;
  logic [31:0] rd_value;
  logic rd_mapped;
  logic [31:0] rd_ctrl_word;
  logic [31:0] rd_sense_word;
  logic [31:0] rd_pend_word;
  logic [31:0] rd_act_word;
  logic [31:0] rd_prio_word;
  logic r_done;
  logic [1:0] next_rresp;

  assign do_rd = s_axi_arvalid_i & ~rvalid;
  assign r_done = rvalid & s_axi_rready_i;
  assign rd_priv = s_axi_arprot_i[0];
  assign rd_word = s_axi_araddr_i[4:2];
  assign rd_pword = s_axi_araddr_i[7:2];
  assign rd_hit_ctrl = (s_axi_araddr_i[11:2] == irq_ctrl_pkg::CTRL_ADDR[11:2]);
  assign rd_hit_sense = (s_axi_araddr_i >= irq_ctrl_pkg::SENSE_BASE) &&
                        (s_axi_araddr_i <= irq_ctrl_pkg::SENSE_BASE +
                         irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  // set and clear views both show pending state
  assign rd_hit_pend = ((s_axi_araddr_i >= irq_ctrl_pkg::SET_BASE) &&
                        (s_axi_araddr_i <= irq_ctrl_pkg::SET_BASE +
                         irq_ctrl_pkg::BITMAP_LAST + 12'h003)) ||
                       ((s_axi_araddr_i >= irq_ctrl_pkg::CLR_BASE) &&
                        (s_axi_araddr_i <= irq_ctrl_pkg::CLR_BASE +
                         irq_ctrl_pkg::BITMAP_LAST + 12'h003));
  assign rd_hit_act = (s_axi_araddr_i >= irq_ctrl_pkg::ACT_BASE) &&
                      (s_axi_araddr_i <= irq_ctrl_pkg::ACT_BASE +
                       irq_ctrl_pkg::BITMAP_LAST + 12'h003);
  assign rd_hit_prio = (s_axi_araddr_i >= irq_ctrl_pkg::PRIO_BASE) &&
                       (s_axi_araddr_i <= irq_ctrl_pkg::PRIO_LAST);
  assign rd_hit_trig = (s_axi_araddr_i[11:2] == irq_ctrl_pkg::TRIG_ADDR[11:2]);
  assign rd_mapped = rd_hit_ctrl | rd_hit_sense | rd_hit_pend | rd_hit_act |
                     rd_hit_prio | rd_hit_trig;
  // word k of a bitmap covers irqs 32k..32k+31 [R24] [R4]
  assign rd_ctrl_word = {31'h00000000, user_pend_permission};
  assign rd_sense_word = sense_pulsed[32*rd_word +: 32];
  assign rd_pend_word = pend_pad[32*rd_word +: 32];
  assign rd_act_word = act_pad[32*rd_word +: 32];
  assign rd_prio_word = prio_pad[32*rd_pword +: 32];
  assign rd_value = !rd_priv ? irq_ctrl_pkg::REG_RESET :
                    rd_hit_ctrl ? rd_ctrl_word :
                    rd_hit_sense ? rd_sense_word :
                    rd_hit_pend ? rd_pend_word :
                    rd_hit_act ? rd_act_word :
                    rd_hit_prio ? rd_prio_word :
                    irq_ctrl_pkg::REG_RESET;
  assign next_rresp = (rd_mapped && rd_priv) ? irq_ctrl_pkg::RESP_OKAY :
                      irq_ctrl_pkg::RESP_SLVERR;

  assign s_axi_awready_o = ~aw_held & ~bvalid;
  assign s_axi_wready_o = ~w_held & ~bvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = ~rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      aw_priv <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
      aw_priv <= s_axi_awprot_i[0];
    end else if (do_wr) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_wr) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bvalid <= 1'b0;
      bresp <= irq_ctrl_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp <= next_bresp;
    end else if (b_done) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rvalid <= 1'b0;
      rdata <= irq_ctrl_pkg::REG_RESET;
      rresp <= irq_ctrl_pkg::RESP_OKAY;
    end else if (do_rd) begin
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= next_rresp;
    end else if (r_done) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      user_pend_permission <= 1'b0;
    end else if (wr_go && wr_hit_ctrl && w_strb[0]) begin
      user_pend_permission <= w_data[irq_ctrl_pkg::PERM_BIT];
    end
  end

  // two-stage synchroniser plus a third stage for edge detection [R11] [R12]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
    end else begin
      req_s1 <= irq_req_i;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // one slice per interrupt number, padded up to the full bitmap [R23]
  for (genvar i = 0; i < irq_ctrl_pkg::BITMAP_W; i++) begin : g_irq
    localparam int unsigned BIT = i % 32;
    localparam int unsigned LANE = i % 4;
    if (i < NUM_IRQ) begin : g_live
      irq_ctrl_pkg::cell_ctrl_s ctrl;
      logic word_sel;
      logic trig_hit;
      logic sense_we;
      logic prio_we;
      assign word_sel = (wr_word == 3'(i / 32)) & w_data[BIT] & w_strb[BIT / 8];
      assign trig_hit = trig_go & (trig_id == irq_ctrl_pkg::TRIG_ID_W'(i));
      assign sense_we = wr_go & wr_hit_sense & (wr_word == 3'(i / 32)) & w_strb[BIT / 8];
      assign prio_we = wr_go & wr_hit_prio & (wr_pword == 6'(i / 4)) & w_strb[LANE];
      assign ctrl.pulsed = sense_pulsed[i];
      assign ctrl.req = req_s2[i];
      assign ctrl.rise = req_s2[i] & ~req_s3[i];
      // set by bitmap or trigger regardless of enable [R2] [R9] [R20]
      assign ctrl.set = (wr_go & wr_hit_set & word_sel) | trig_hit;
      assign ctrl.clr = wr_go & wr_hit_clr & word_sel;
      assign ctrl.enter = handler_entry_i & (handler_irq_i == 8'(i));
      assign ctrl.ret = handler_return_i & (handler_irq_i == 8'(i));

      irq_state_cell u_cell (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ctrl_i(ctrl),
        .active_o(active_o[i]),
        .pending_o(pending_o[i])
      );

      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          sense_q[i] <= 1'b0;
        end else if (sense_we) begin
          sense_q[i] <= w_data[BIT];
        end
      end
      assign sense_pulsed[i] = sense_q[i];

      // byte-lane write of the upper bits only [R5] [R7] [R8] [R6]
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          prio[i] <= '0;
        end else if (prio_we) begin
          prio[i] <= w_data[LANE*8+irq_ctrl_pkg::PRIO_FIELD_W-PRIO_BITS +: PRIO_BITS];
        end
      end

      assign pend_pad[i] = pending_o[i];
      assign act_pad[i] = active_o[i];
      // unimplemented low bits read as zero [R6]
      assign prio_pad[i*8 +: 8] = {prio[i], {(irq_ctrl_pkg::PRIO_FIELD_W-PRIO_BITS){1'b0}}};
    end else begin : g_pad
      assign pend_pad[i] = 1'b0;
      assign act_pad[i] = 1'b0;
      assign sense_pulsed[i] = 1'b0;
      if (i < irq_ctrl_pkg::MAX_IRQ) begin : g_prio_pad
        assign prio_pad[i*8 +: 8] = 8'h00;
      end
    end
  end

  // pick the most urgent pending enabled idle irq [R22] [R25]
  assign cand = pending_o & irq_enable_i & ~active_o;
  always_comb begin
    next_sel = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (cand[i] &&
          (!next_sel.valid || (prio_pad[i*8 +: 8] < next_sel.prio))) begin
        next_sel.valid = 1'b1;
        next_sel.irq = 8'(i);
        next_sel.prio = prio_pad[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sel_o <= '0;
    end else begin
      sel_o <= next_sel;
    end
  end
endmodule : irq_pending_priority_ctrl

// ### logic/irq_ctrl_pkg.sv
// Contract
// R1: set-pending one on pending irq changes nothing
// R2: set-pending works even on disabled irq
// R3: clear-pending never touches active condition
// R4: active flag reads one when active or both
// R5: eight-bit priority per irq, lower is urgent
// R6: low unimplemented priority bits read zero
// R7: priority registers accept byte accesses
// R8: irq m in word m/4, lane m%4
// R9: trigger write pends irq named by id
// R10: unprivileged trigger only with permission bit
// R11: pulsed request high at least one cycle
// R12: pulsed request sampled on rising clock edge
// R13: handler entry clears pending, sets active
// R14: level high while not active makes pending
// R15: rising edge on request makes pending
// R16: level return samples request, pend or idle
// R17: pulse during handler gives active and pending
// R18: level clear keeps state while request high
// R19: pulse clear: pending idles, both becomes active
// R20: disabled irq may still become pending
// R21: software uses naturally aligned accesses only
// R22: pending enabled irq considered by priority
// R23: irq count is a build parameter
// R24: bitmap bit b of word k is 32k+b
// R25: lowest priority value wins, then lowest number
package irq_ctrl_pkg;
  localparam int unsigned MAX_IRQ = 240;
  localparam int unsigned BITMAP_WORDS = 8;
  localparam int unsigned BITMAP_W = 256;
  localparam int unsigned PRIO_WORDS = 60;
  localparam int unsigned PRIO_FIELD_W = 8;
  localparam int unsigned TRIG_ID_W = 9;
  localparam int unsigned PERM_BIT = 0;
  localparam logic [11:0] CTRL_ADDR = 12'h010;
  localparam logic [11:0] SENSE_BASE = 12'h080;
  localparam logic [11:0] SET_BASE = 12'h200;
  localparam logic [11:0] CLR_BASE = 12'h280;
  localparam logic [11:0] ACT_BASE = 12'h300;
  localparam logic [11:0] BITMAP_LAST = 12'h01c;
  localparam logic [11:0] PRIO_BASE = 12'h400;
  localparam logic [11:0] PRIO_LAST = 12'h4ef;
  localparam logic [11:0] TRIG_ADDR = 12'hf00;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    ST_INACTIVE = 2'b00,
    ST_PENDING = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_ACT_PEND = 2'b11
  } irq_state_e;
  typedef struct packed {
    logic pulsed;
    logic req;
    logic rise;
    logic set;
    logic clr;
    logic enter;
    logic ret;
  } cell_ctrl_s;
  typedef struct packed {
    logic valid;
    logic [7:0] irq;
    logic [7:0] prio;
  } sel_s;
endpackage : irq_ctrl_pkg

// ### logic/irq_state_cell.sv
`timescale 1ns/1ns
module irq_state_cell (
  input wire logic clk_i,
  input wire logic rstn_i,
  input irq_ctrl_pkg::cell_ctrl_s ctrl_i,
  output logic active_o,
  output logic pending_o
);
  irq_ctrl_pkg::irq_state_e state;
  irq_ctrl_pkg::irq_state_e next_state;
  logic cur_act;
  logic cur_pend;
  logic hw_set;
  logic clr_eff;
  logic keep;
  logic next_act;
  logic next_pend;

  always_comb begin
    case (state)
      irq_ctrl_pkg::ST_INACTIVE: {cur_act, cur_pend} = 2'b00;
      irq_ctrl_pkg::ST_PENDING: {cur_act, cur_pend} = 2'b01;
      irq_ctrl_pkg::ST_ACTIVE: {cur_act, cur_pend} = 2'b10;
      irq_ctrl_pkg::ST_ACT_PEND: {cur_act, cur_pend} = 2'b11;
      default: {cur_act, cur_pend} = 2'b00;
    endcase
  end

  // pulsed: edge pends [R15] [R17]; level: high while idle or on return [R14] [R16]
  assign hw_set = ctrl_i.pulsed ? ctrl_i.rise :
                  (ctrl_i.req & ((~cur_act & ~ctrl_i.enter) | ctrl_i.ret));
  // level clear has no effect while request held [R18] [R19]
  assign clr_eff = ctrl_i.clr & (ctrl_i.pulsed | ~ctrl_i.req);
  // level return resamples the line instead of keeping pending [R16] [R17]
  assign keep = cur_pend & ~ctrl_i.enter & ~clr_eff & ~(ctrl_i.ret & ~ctrl_i.pulsed);
  // events win over a clear in the same cycle [R1] [R2] [R20]
  assign next_pend = ctrl_i.set | hw_set | keep;
  // entry sets active, clear leaves active alone [R13] [R3]
  assign next_act = ctrl_i.enter | (cur_act & ~ctrl_i.ret);
  assign next_state = irq_ctrl_pkg::irq_state_e'({next_act, next_pend});

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= irq_ctrl_pkg::ST_INACTIVE;
    end else begin
      state <= next_state;
    end
  end

  assign active_o = cur_act;
  assign pending_o = cur_pend;
endmodule : irq_state_cell

// ### testbench/irq_ctrl_props.sv
`timescale 1ns/1ns
module irq_ctrl_props #(
  parameter int unsigned NUM_IRQ = 240,
  parameter int unsigned PRIO_BITS = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_IRQ-1:0] irq_enable_i,
  input wire logic handler_entry_i,
  input wire logic handler_return_i,
  input wire logic [7:0] handler_irq_i,
  input wire logic [NUM_IRQ-1:0] pending_o,
  input wire logic [NUM_IRQ-1:0] active_o,
  input irq_ctrl_pkg::sel_s sel_o
);
  localparam logic [7:0] LOW_MASK = 8'hff >> PRIO_BITS;
  logic [NUM_IRQ-1:0] cand_q;
  always_ff @(posedge clk_i) begin
    cand_q <= pending_o & irq_enable_i & ~active_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write not answered");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("read answer withdrawn");
  entry_active_a: assert property (handler_entry_i && handler_irq_i < NUM_IRQ
    |=> active_o[$past(handler_irq_i)]) else $error("entry left irq inactive");
  return_idle_a: assert property (handler_return_i && handler_irq_i < NUM_IRQ
    |=> !active_o[$past(handler_irq_i)]) else $error("return left irq active");
  active_keep_a: assert property (!handler_return_i
    |=> (~active_o & $past(active_o)) == '0) else $error("active dropped without return");
  pend_keep_a: assert property (!handler_entry_i && !handler_return_i
    |=> $rose(s_axi_bvalid_o) || ((~pending_o & $past(pending_o)) == '0))
    else $error("pending dropped without cause");
  sel_cand_a: assert property (sel_o.valid |-> cand_q[sel_o.irq])
    else $error("selected irq not a candidate");
  sel_none_a: assert property (!sel_o.valid |-> cand_q == '0)
    else $error("candidate not selected");
  sel_prio_a: assert property (sel_o.valid |-> (sel_o.prio & LOW_MASK) == 8'h00)
    else $error("unimplemented priority bits set");
endmodule : irq_ctrl_props
bind irq_pending_priority_ctrl irq_ctrl_props #(.NUM_IRQ(NUM_IRQ), .PRIO_BITS(PRIO_BITS))
  i_props (.*);

// ### testbench/irq_source_model.sv
`timescale 1ns/1ns
module irq_source_model #(
  parameter int unsigned NUM_IRQ = 240
) (
  input wire logic clk_i,
  output logic [NUM_IRQ-1:0] req_o
);
  logic [NUM_IRQ-1:0] level = '0;
  logic [NUM_IRQ-1:0] pulse = '0;
  assign req_o = level | pulse;
  task automatic raise(input int n, input logic v);
    @(posedge clk_i);
    level[n] <= v;
  endtask : raise
  // pulse held w whole cycles, w of one is the shortest legal pulse
  task automatic pulse_line(input int n, input int w);
    @(posedge clk_i);
    pulse[n] <= 1'b1;
    repeat (w) @(posedge clk_i);
    pulse[n] <= 1'b0;
  endtask : pulse_line
endmodule : irq_source_model

// ### testbench/irq_pending_priority_ctrl_tb.sv
`timescale 1ns/1ns
module irq_pending_priority_ctrl_tb;
  localparam int unsigned NUM_IRQ = 40;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] s_axi_awaddr_i = '0;
  logic [11:0] s_axi_araddr_i = '0;
  logic [2:0] s_axi_awprot_i = '0;
  logic [2:0] s_axi_arprot_i = '0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = '0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic [31:0] s_axi_rdata_o, d;
  logic [NUM_IRQ-1:0] irq_req_i, pending_o, active_o;
  logic [NUM_IRQ-1:0] irq_enable_i = '0;
  logic handler_entry_i = 1'b0;
  logic handler_return_i = 1'b0;
  logic [7:0] handler_irq_i = '0;
  irq_ctrl_pkg::sel_s sel_o;
  int bad_count = 0;
  int checks = 0;
  always #2 clk_i = ~clk_i;
  irq_source_model #(.NUM_IRQ(NUM_IRQ)) i_src (.clk_i(clk_i), .req_o(irq_req_i));
  irq_pending_priority_ctrl #(.NUM_IRQ(NUM_IRQ), .PRIO_BITS(4)) i_dut (.*);
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n > 100) begin
      bad_count++;
      $display("[FAIL] bus answer expected done seen timeout");
      results();
    end
  endtask : tmo
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [2:0] p);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awprot_i <= p;
    s_axi_wdata_i <= v;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      tmo(n);
      n++;
    end while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : wr
  task automatic wp(input logic [11:0] a, input logic [31:0] v);
    wr(a, v, 4'hf, 3'b001);
  endtask : wp
  task automatic rd(input logic [11:0] a, input logic [2:0] p);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arprot_i <= p;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      tmo(n);
      n++;
    end while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rd
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    rd(a, 3'b001);
    chk(n, e, d);
  endtask : rc
  task automatic rs(input logic [1:0] e);
    chk("resp", {30'h0, e}, {30'h0, r});
  endtask : rs
  task automatic st(input int n, input logic [1:0] e);
    wt(1);
    chk("state", {30'h0, e}, {30'h0, active_o[n], pending_o[n]});
  endtask : st
  task automatic hnd(input logic e, input logic [7:0] n);
    @(posedge clk_i);
    handler_irq_i <= n;
    handler_entry_i <= e;
    handler_return_i <= !e;
    @(posedge clk_i);
    handler_entry_i <= 1'b0;
    handler_return_i <= 1'b0;
  endtask : hnd
  task automatic sel(input logic [7:0] n, input logic [7:0] p);
    wt(3);
    chk("sel", {15'h0, 1'b1, n, p}, {15'h0, sel_o});
  endtask : sel
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc("pending", 12'h200, 32'h0);
    rc("active", 12'h300, 32'h0);
    rc("prio", 12'h400, 32'h0);
    $display("reset test done");
    wp(12'h200, 32'h20);
    wp(12'h200, 32'h20);
    wp(12'h204, 32'h8);
    rc("pending", 12'h200, 32'h20);
    rc("pending", 12'h204, 32'h8);
    st(35, 2'b01);
    wp(12'h400, 32'h44332211);
    wr(12'h400, 32'h0000ff00, 4'h2, 3'b001);
    rc("prio", 12'h400, 32'h4030f010);
    wr(12'h420, 32'h10000000, 4'h8, 3'b001);
    rc("prio", 12'h420, 32'h10000000);
    wt(1);
    chk("sel", 32'h0, {15'h0, sel_o});
    @(posedge clk_i);
    irq_enable_i <= '1;
    sel(8'd5, 8'h00);
    wr(12'h404, 32'h0000f000, 4'h2, 3'b001);
    sel(8'd35, 8'h10);
    wr(12'h420, 32'hf0000000, 4'h8, 3'b001);
    sel(8'd5, 8'hf0);
    $display("pending and priority test done");
    hnd(1'b1, 8'd35);
    st(35, 2'b10);
    wp(12'h204, 32'h8);
    st(35, 2'b11);
    wp(12'h304, 32'h0);
    rc("active", 12'h304, 32'h8);
    wp(12'h284, 32'h8);
    st(35, 2'b10);
    hnd(1'b0, 8'd35);
    st(35, 2'b00);
    i_src.raise(7, 1'b1);
    wt(5);
    st(7, 2'b01);
    wp(12'h280, 32'h80);
    st(7, 2'b01);
    hnd(1'b1, 8'd7);
    st(7, 2'b10);
    hnd(1'b0, 8'd7);
    st(7, 2'b01);
    i_src.raise(7, 1'b0);
    wt(4);
    wp(12'h280, 32'h80);
    st(7, 2'b00);
    $display("level test done");
    wp(12'h080, 32'h200);
    i_src.pulse_line(9, 1);
    wt(4);
    st(9, 2'b01);
    hnd(1'b1, 8'd9);
    i_src.pulse_line(9, 3);
    wt(4);
    st(9, 2'b11);
    wp(12'h280, 32'h200);
    st(9, 2'b10);
    i_src.pulse_line(9, 1);
    wt(4);
    hnd(1'b0, 8'd9);
    st(9, 2'b01);
    wp(12'h280, 32'h200);
    st(9, 2'b00);
    hnd(1'b1, 8'd9);
    hnd(1'b0, 8'd9);
    st(9, 2'b00);
    $display("pulse test done");
    wp(12'hf00, 32'd12);
    st(12, 2'b01);
    wr(12'hf00, 32'd13, 4'hf, 3'b000);
    rs(irq_ctrl_pkg::RESP_SLVERR);
    st(13, 2'b00);
    wp(12'h010, 32'h1);
    wr(12'hf00, 32'd13, 4'hf, 3'b000);
    rs(irq_ctrl_pkg::RESP_OKAY);
    st(13, 2'b01);
    wp(12'hf00, 32'hfffffe0e);
    st(14, 2'b01);
    rd(12'h800, 3'b001);
    rs(irq_ctrl_pkg::RESP_SLVERR);
    $display("trigger and bus test done");
    results();
  end
endmodule : irq_pending_priority_ctrl_tb
